// [design/sfcmd_regs.svh]
/*
  Opcode values, byte counts and reset values for the setting, identity and
  reset command decoder. Assumes inclusion by bare name from design files.
*/
`ifndef SFCMD_REGS_SVH
`define SFCMD_REGS_SVH

`define SFCMD_OP_NOP        8'h00
`define SFCMD_OP_WSTAT      8'h01
`define SFCMD_OP_LCLR       8'h04
`define SFCMD_OP_RSTAT      8'h05
`define SFCMD_OP_LSET       8'h06
`define SFCMD_OP_RCFG       8'h15
`define SFCMD_OP_RSEC       8'h2b
`define SFCMD_OP_LOCK       8'h2f
`define SFCMD_OP_RESUME_B   8'h30
`define SFCMD_OP_FACT       8'h41
`define SFCMD_OP_RFSTAT     8'h44
`define SFCMD_OP_RSTARM     8'h66
`define SFCMD_OP_SUSP_A     8'h75
`define SFCMD_OP_RESUME_A   8'h7a
`define SFCMD_OP_MDID       8'h90
`define SFCMD_OP_RST        8'h99
`define SFCMD_OP_JID        8'h9f
`define SFCMD_OP_LEGACY     8'hab
`define SFCMD_OP_SUSP_B     8'hb0
`define SFCMD_OP_OTPIN      8'hb1
`define SFCMD_OP_SLEEP      8'hb9
`define SFCMD_OP_WRAP       8'hc0
`define SFCMD_OP_OTPOUT     8'hc1

`define SFCMD_SEL_MAKER     8'h00
`define SFCMD_SEL_DEVICE    8'h01

`define SFCMD_BYTE2         3'h1
`define SFCMD_BYTE3         3'h2
`define SFCMD_BYTE4         3'h3
`define SFCMD_BIT_LAST      3'h7
`define SFCMD_LOCK_BIT      1

`define SFCMD_STAT_RST      8'h00
`define SFCMD_CFG_RST       8'h00
`define SFCMD_WRAP_RST      8'h10
`define SFCMD_SEC_RST       8'h00

`endif

// [design/sfcmd_pkg.sv]
/*
  Types shared by the command decoder files.
  Assumes nothing of its surroundings.
*/
package sfcmd_pkg;
  typedef logic [7:0] sfcmd_byte_t;
  typedef enum logic [2:0] {
    SFCMD_SRC_STAT, SFCMD_SRC_CFG, SFCMD_SRC_FSTAT, SFCMD_SRC_SEC,
    SFCMD_SRC_JID, SFCMD_SRC_LEGACY, SFCMD_SRC_MDID, SFCMD_SRC_NONE
  } sfcmd_src_t;
endpackage : sfcmd_pkg

// [design/sfcmd_sync.sv]
/*
  Two-flop synchroniser for the serial pins.
  Assumes inputs asynchronous to core_clk.
*/
`timescale 1ns/1ps
module sfcmd_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic async_in,
  input  wire logic reset_val,
  output logic      sync_out
);
  logic stage1;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1   <= reset_val;
      sync_out <= reset_val;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : sfcmd_sync

// [design/sfcmd_shift.sv]
/*
  Serial byte receiver: shifts in MSB first on rising clock edges and
  flags each completed byte. Assumes synchronised pin levels and edges.
*/
`timescale 1ns/1ps
module sfcmd_shift
  import sfcmd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        frame,
  input  wire logic        rise,
  input  wire logic        din,
  output sfcmd_pkg::sfcmd_byte_t rx_byte,
  output logic             byte_done
);
  `include "sfcmd_regs.svh"
  logic [2:0] bit_cnt;
  logic [6:0] partial;

  always_ff @(posedge core_clk) begin
    if (rst || !frame) begin
      bit_cnt   <= 3'h0;
      partial   <= 7'h00;
      byte_done <= 1'b0;
      rx_byte   <= 8'h00;
    end else begin
      byte_done <= 1'b0;
      if (rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        partial <= {partial[5:0], din};
        if (bit_cnt == `SFCMD_BIT_LAST) begin
          rx_byte   <= {partial, din};
          byte_done <= 1'b1;
        end
      end
    end
  end
endmodule : sfcmd_shift

// [design/sfcmd_top.sv]
/*
  Command decoder for register-setting, identification and reset opcodes
  of a serial NOR flash. Assumes SPI mode 0 host, sclk much slower than
  core_clk (at least four core cycles per half period).
*/
// Functional notes
// [R01] Opcode 06h sets the write-enable latch; no further bytes.
// [R02] Opcode 04h clears the write-enable latch; no further bytes.
// [R03] Opcode 41h enters factory mode to speed later erases.
// [R04] Opcode 05h shifts the status register out.
// [R05] Opcode 15h shifts configuration one then configuration two out.
// [R06] Opcode 01h takes up to three bytes as new status and configuration.
// [R07] Opcodes 75h or B0h suspend a running program or erase.
// [R08] Opcodes 7Ah or 30h resume the suspended program or erase.
// [R09] Opcode B9h alone enters deep power-down.
// [R10] Opcode C0h takes one byte setting burst wrap length.
// [R11] Opcode 44h shifts the factory status register out.
// [R12] Opcode 9Fh outputs maker byte then two device bytes.
// [R13] Opcode ABh takes three dummy bytes then outputs the device byte.
// [R14] Opcode 90h takes two dummies and a selector, then outputs codes.
// [R15] Selector 00h gives maker first; 01h gives device first.
// [R16] Opcode B1h switches array accesses into the secured OTP region.
// [R17] Opcode C1h returns array accesses to the normal array.
// [R18] Opcode 2Bh shifts the security register out.
// [R19] Opcode 2Fh sets the lock-down bit, which never clears again.
// [R20] Opcode 00h changes no state; the code still clears reset_armed at the end of a 00h frame.
// [R21] Reset 99h acts only directly after reset-arm 66h.
// [R22] Host must not send opcodes outside the command set.
// [R23] Single-byte commands act only on exactly eight bits then select high.
// [R24] Three-byte identification is not decoded while program or erase runs.
// [R25] Identity bytes go out MSB first on falling edges, repeating.
// [R26] Register write updates only bytes fully received before select rose.
`timescale 1ns/1ps
module sfcmd_top
  import sfcmd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  input  wire logic        busy,
  input  sfcmd_pkg::sfcmd_byte_t fact_status,
  input  sfcmd_pkg::sfcmd_byte_t maker_code,
  input  sfcmd_pkg::sfcmd_byte_t dev_code_hi,
  input  sfcmd_pkg::sfcmd_byte_t dev_code_lo,
  input  sfcmd_pkg::sfcmd_byte_t legacy_code,
  output logic             write_enable_latch,
  output logic             factory_mode,
  output logic             suspend_pulse,
  output logic             resume_pulse,
  output logic             deep_sleep,
  output logic             otp_mode,
  output logic             soft_reset_pulse,
  output sfcmd_pkg::sfcmd_byte_t status_reg,
  output sfcmd_pkg::sfcmd_byte_t config1_reg,
  output sfcmd_pkg::sfcmd_byte_t config2_reg,
  output sfcmd_pkg::sfcmd_byte_t wrap_length,
  output sfcmd_pkg::sfcmd_byte_t security_reg
);
  import sfcmd_pkg::*;
  `include "sfcmd_regs.svh"

  // ==========================================================
  // Pin synchronisation and edge detection
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic sclk_d;
  logic frame;
  logic rise;
  logic fall;
  logic frame_d;
  logic frame_end;

  sfcmd_sync u_sync_cs (.core_clk(core_clk), .rst(rst), .async_in(cs_n),
                        .reset_val(1'b1), .sync_out(cs_n_s));
  sfcmd_sync u_sync_ck (.core_clk(core_clk), .rst(rst), .async_in(sclk),
                        .reset_val(1'b0), .sync_out(sclk_s));
  sfcmd_sync u_sync_si (.core_clk(core_clk), .rst(rst), .async_in(si),
                        .reset_val(1'b0), .sync_out(si_s));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_d  <= 1'b0;
      frame_d <= 1'b0;
    end else begin
      sclk_d  <= sclk_s;
      frame_d <= frame;
    end
  end

  assign frame     = !cs_n_s;
  assign rise      = frame && sclk_s && !sclk_d;
  assign fall      = frame && !sclk_s && sclk_d;
  assign frame_end = frame_d && !frame;

  // ==========================================================
  // Byte receiver
  sfcmd_byte_t rx_byte;
  logic        byte_done;

  sfcmd_shift u_shift (.core_clk(core_clk), .rst(rst), .frame(frame), .rise(rise),
                       .din(si_s), .rx_byte(rx_byte), .byte_done(byte_done));

  // ==========================================================
  // Frame bookkeeping
  sfcmd_byte_t opcode;
  logic [2:0]  byte_cnt;
  logic        extra_bits;
  logic        have_op;
  sfcmd_byte_t selector;
  logic        reset_armed;

  always_ff @(posedge core_clk) begin
    if (rst || !frame) begin
      byte_cnt   <= 3'h0;
      have_op    <= 1'b0;
      opcode     <= `SFCMD_OP_NOP;
      selector   <= `SFCMD_SEL_MAKER;
    end else if (byte_done) begin
      if (!have_op) begin
        opcode  <= rx_byte;
        have_op <= 1'b1;
      end
      if (byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (have_op && opcode == `SFCMD_OP_MDID && byte_cnt == `SFCMD_BYTE4) begin
        selector <= rx_byte; // [R14]
      end
    end
  end

  // Any rising edge past the opcode disqualifies a one-byte command
  always_ff @(posedge core_clk) begin
    if (rst || !frame) begin
      extra_bits <= 1'b0;
    end else if (rise && have_op) begin
      extra_bits <= 1'b1;
    end
  end

  logic single_ok;
  assign single_ok = frame_end && have_op && !extra_bits && byte_cnt == 3'h1; // [R23]

  // ==========================================================
  // One-byte setting commands, acted on at select rising
  logic soft_reset_cmd;
  assign soft_reset_cmd = single_ok && opcode == `SFCMD_OP_RST && reset_armed; // [R21]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (single_ok && opcode == `SFCMD_OP_LSET) begin
      write_enable_latch <= 1'b1; // [R01]
    end else if (single_ok && (opcode == `SFCMD_OP_LCLR || soft_reset_cmd)) begin
      write_enable_latch <= 1'b0; // [R02]
    end
  end

  // Arm survives only until the very next complete command frame
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_armed <= 1'b0;
    end else if (frame_end && have_op) begin
      reset_armed <= single_ok && opcode == `SFCMD_OP_RSTARM; // [R21]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || soft_reset_cmd) begin
      factory_mode <= 1'b0;
      deep_sleep   <= 1'b0;
      otp_mode     <= 1'b0;
    end else if (single_ok) begin
      case (opcode)
        `SFCMD_OP_FACT:   factory_mode <= 1'b1; // [R03]
        `SFCMD_OP_SLEEP:  deep_sleep   <= 1'b1; // [R09]
        `SFCMD_OP_OTPIN:  otp_mode     <= 1'b1; // [R16]
        `SFCMD_OP_OTPOUT: otp_mode     <= 1'b0; // [R17]
        default:          ;                     // [R20]
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      suspend_pulse    <= 1'b0;
      resume_pulse     <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      suspend_pulse <= single_ok && (opcode == `SFCMD_OP_SUSP_A ||
                                     opcode == `SFCMD_OP_SUSP_B); // [R07]
      resume_pulse  <= single_ok && (opcode == `SFCMD_OP_RESUME_A ||
                                     opcode == `SFCMD_OP_RESUME_B); // [R08]
      soft_reset_pulse <= soft_reset_cmd; // [R21]
    end
  end

  // ==========================================================
  // Written registers: each data byte lands only when complete
  logic data_byte;
  assign data_byte = byte_done && have_op;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg  <= `SFCMD_STAT_RST;
      config1_reg <= `SFCMD_CFG_RST;
      config2_reg <= `SFCMD_CFG_RST;
    end else if (data_byte && opcode == `SFCMD_OP_WSTAT) begin
      case (byte_cnt)
        `SFCMD_BYTE2: status_reg  <= rx_byte; // [R06] [R26]
        `SFCMD_BYTE3: config1_reg <= rx_byte; // [R06] [R26]
        `SFCMD_BYTE4: config2_reg <= rx_byte; // [R06] [R26]
        default:      ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrap_length <= `SFCMD_WRAP_RST;
    end else if (data_byte && opcode == `SFCMD_OP_WRAP && byte_cnt == `SFCMD_BYTE2) begin
      wrap_length <= rx_byte; // [R10]
    end
  end

  // Lock-down bit is sticky: only rst clears it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      security_reg <= `SFCMD_SEC_RST;
    end else if (single_ok && opcode == `SFCMD_OP_LOCK) begin
      security_reg[`SFCMD_LOCK_BIT] <= 1'b1; // [R19]
    end
  end

  // ==========================================================
  // Read-out source selection
  sfcmd_src_t src;
  logic       out_start;
  logic [1:0] out_idx;
  logic       read_live;

  always_comb begin
    src = SFCMD_SRC_NONE;
    case (opcode)
      `SFCMD_OP_RSTAT:  src = SFCMD_SRC_STAT;  // [R04]
      `SFCMD_OP_RCFG:   src = SFCMD_SRC_CFG;   // [R05]
      `SFCMD_OP_RFSTAT: src = SFCMD_SRC_FSTAT; // [R11]
      `SFCMD_OP_RSEC:   src = SFCMD_SRC_SEC;   // [R18]
      `SFCMD_OP_JID:    src = busy ? SFCMD_SRC_NONE : SFCMD_SRC_JID; // [R24]
      `SFCMD_OP_LEGACY: src = SFCMD_SRC_LEGACY; // [R13]
      `SFCMD_OP_MDID:   src = SFCMD_SRC_MDID;   // [R14]
      default:          src = SFCMD_SRC_NONE;
    endcase
  end

  // Data phase starts after the opcode, or after the dummy and selector bytes
  always_comb begin
    case (src)
      SFCMD_SRC_LEGACY: out_start = byte_cnt > `SFCMD_BYTE4;
      SFCMD_SRC_MDID:   out_start = byte_cnt > `SFCMD_BYTE4;
      SFCMD_SRC_NONE:   out_start = 1'b0;
      default:          out_start = have_op;
    endcase
  end

  function automatic sfcmd_byte_t pick(input sfcmd_src_t s, input logic [1:0] i,
                                       input logic dev_first);
    logic alt;
    alt = i[0] ^ dev_first;
    case (s)
      SFCMD_SRC_STAT:   pick = status_reg;
      SFCMD_SRC_CFG:    pick = i[0] ? config2_reg : config1_reg;
      SFCMD_SRC_FSTAT:  pick = fact_status;
      SFCMD_SRC_SEC:    pick = security_reg;
      SFCMD_SRC_JID:    pick = (i == 2'h0) ? maker_code :
                               (i == 2'h1) ? dev_code_hi : dev_code_lo; // [R12]
      SFCMD_SRC_LEGACY: pick = legacy_code;
      SFCMD_SRC_MDID:   pick = alt ? legacy_code : maker_code; // [R15] [R25]
      default:          pick = 8'h00;
    endcase
  endfunction : pick

  // ==========================================================
  // Output shifter: loads on the falling edge that ends each byte
  logic [2:0]  obit;
  sfcmd_byte_t oshift;
  logic        dev_first;
  logic [1:0]  next_idx;

  assign dev_first = selector == `SFCMD_SEL_DEVICE; // [R15]

  always_comb begin
    if (src == SFCMD_SRC_JID) begin
      next_idx = (out_idx == 2'h2) ? 2'h0 : out_idx + 2'h1;
    end else begin
      next_idx = out_idx + 2'h1;
    end
  end

  // Byte for the next boundary, picked once so its bits can be split
  sfcmd_byte_t load_byte;
  logic [1:0]  load_idx;

  assign load_idx  = read_live ? next_idx : 2'h0;
  assign load_byte = pick(src, load_idx, dev_first);

  always_ff @(posedge core_clk) begin
    if (rst || !frame) begin
      read_live <= 1'b0;
      obit      <= 3'h0;
      out_idx   <= 2'h0;
      oshift    <= 8'h00;
      so        <= 1'b0;
    end else if (fall && out_start) begin
      if (!read_live || obit == 3'h0) begin
        oshift    <= {load_byte[6:0], 1'b0};
        so        <= load_byte[7]; // [R25]
        out_idx   <= load_idx;
        read_live <= 1'b1;
        obit      <= `SFCMD_BIT_LAST;
      end else begin
        so     <= oshift[7];
        oshift <= {oshift[6:0], 1'b0};
        obit   <= obit - 3'h1;
      end
    end
  end

  assign so_oe = read_live && frame;
endmodule : sfcmd_top

// [bench/sfcmd_host.sv]
/*
  Mode 0 serial host model: drives select, clock and data, samples so.
  Assumes core_clk only for placing select edges; sclk is free in phase.
*/
`timescale 1ns/1ps
module sfcmd_host (
  input  wire logic core_clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  // ==========================================
  // Frame engine
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // Only opcodes from the command set are ever sent
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    @(posedge core_clk);
    #1 cs_n = 1'b0;
    #137;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      #400 sclk = 1'b1;
      // Undriven line reads as the inverse of the last driven level
      rx[i] = so_oe ? so : ~so;
      #400 sclk = 1'b0;
    end
    // Data line no longer valid after the last bit
    si = ~si;
    #400;
    @(posedge core_clk);
    #1 cs_n = 1'b1;
    #1000;
  endtask : xfer
endmodule : sfcmd_host

// [bench/sfcmd_top_asserts.sv]
/*
  Port-level assertions for the command decoder.
  Assumes binding into every sfcmd_top instance.
*/
`timescale 1ns/1ps
module sfcmd_top_asserts
  import sfcmd_pkg::*;
(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             cs_n,
  input wire logic             so_oe,
  input wire logic             write_enable_latch,
  input wire logic             factory_mode,
  input wire logic             suspend_pulse,
  input wire logic             resume_pulse,
  input wire logic             deep_sleep,
  input wire logic             otp_mode,
  input wire logic             soft_reset_pulse,
  input sfcmd_pkg::sfcmd_byte_t wrap_length,
  input sfcmd_pkg::sfcmd_byte_t security_reg
);
  import sfcmd_pkg::*;
  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_vals: assert property ($fell(rst) |-> wrap_length == 8'h10 && !write_enable_latch)
    else $error("reset values wrong");
  a_susp_single: assert property (suspend_pulse |=> !suspend_pulse)
    else $error("suspend pulse too long");
  a_resume_single: assert property (resume_pulse |=> !resume_pulse)
    else $error("resume pulse too long");
  a_srst_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  a_oe_idle: assert property (cs_n [*8] |-> !so_oe)
    else $error("so driven while deselected");
  a_lock_sticky: assert property (security_reg[1] |=> security_reg[1])
    else $error("lock bit cleared");
  a_wel_on_cs: assert property ($changed(write_enable_latch) |-> cs_n)
    else $error("latch changed mid frame");
  a_sleep_on_cs: assert property ($rose(deep_sleep) |-> cs_n)
    else $error("sleep entered mid frame");
  a_srst_clears: assert property (soft_reset_pulse |=>
      !write_enable_latch && !factory_mode && !otp_mode && !deep_sleep)
    else $error("soft reset left modes set");

  c_srst: cover property (soft_reset_pulse);
  c_susp: cover property (suspend_pulse);
  c_read: cover property (so_oe && !cs_n);
endmodule : sfcmd_top_asserts

bind sfcmd_top sfcmd_top_asserts sfcmd_top_asserts_i (.core_clk, .rst, .cs_n, .so_oe,
  .write_enable_latch, .factory_mode, .suspend_pulse, .resume_pulse, .deep_sleep,
  .otp_mode, .soft_reset_pulse, .wrap_length, .security_reg);

// [bench/sfcmd_top_tb.sv]
/*
  Self-checking bench for the command decoder.
  Assumes the host model and the bound checker from bench/.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", n, e, g); fails++; end end
module sfcmd_top_tb;
  import sfcmd_pkg::*;
  logic        core_clk, rst, busy, cs_n, sclk, si, so, so_oe;
  logic        write_enable_latch, factory_mode, suspend_pulse, resume_pulse;
  logic        deep_sleep, otp_mode, soft_reset_pulse;
  sfcmd_byte_t fact_status, maker_code, dev_code_hi, dev_code_lo, legacy_code;
  sfcmd_byte_t status_reg, config1_reg, config2_reg, wrap_length, security_reg;
  logic [47:0] rx;
  logic [7:0]  ops [4] = '{8'h75, 8'hb0, 8'h7a, 8'h30};
  int          fails = 0, check_count = 0, n_susp = 0, n_res = 0, n_srst = 0;
  int          n_oe = 0, oe_base = 0;

  // ==========================================
  // Structure
  sfcmd_top sfcmd_top_i (.core_clk, .rst, .cs_n, .sclk, .si, .so, .so_oe, .busy,
    .fact_status, .maker_code, .dev_code_hi, .dev_code_lo, .legacy_code,
    .write_enable_latch, .factory_mode, .suspend_pulse, .resume_pulse, .deep_sleep,
    .otp_mode, .soft_reset_pulse, .status_reg, .config1_reg, .config2_reg,
    .wrap_length, .security_reg);
  sfcmd_host sfcmd_host_i (.core_clk, .so, .so_oe, .cs_n, .sclk, .si);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    n_susp <= n_susp + int'(suspend_pulse);
    n_res  <= n_res + int'(resume_pulse);
    n_srst <= n_srst + int'(soft_reset_pulse);
    n_oe   <= n_oe + int'(so_oe === 1'b1);
  end

  task automatic op(input logic [7:0] c);
    sfcmd_host_i.xfer(8, {40'h0, c}, rx);
  endtask : op

  task automatic finish_test;
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial begin
    #3000000;
    fails++;
    finish_test();
  end

  // ==========================================
  // Sequence
  initial begin
    rst = 1'b1;
    busy = 1'b0;
    fact_status = 8'ha5;
    // Identity values are arbitrary
    maker_code = 8'h5a;
    dev_code_hi = 8'h3c;
    dev_code_lo = 8'h96;
    legacy_code = 8'h69;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("wrap", 8'h10, wrap_length)
    op(8'h06);
    `CHK("wel", 1'b1, write_enable_latch)
    op(8'h04);
    `CHK("wel", 1'b0, write_enable_latch)
    sfcmd_host_i.xfer(9, 48'h00c, rx);
    `CHK("wel9", 1'b0, write_enable_latch)
    op(8'h41);
    `CHK("fact", 1'b1, factory_mode)
    op(8'hb9);
    `CHK("sleep", 1'b1, deep_sleep)
    op(8'hb1);
    `CHK("otp", 1'b1, otp_mode)
    op(8'hc1);
    `CHK("otp", 1'b0, otp_mode)
    sfcmd_host_i.xfer(32, 48'h01112233, rx);
    `CHK("stat", 8'h11, status_reg)
    `CHK("cfg", 16'h2233, {config1_reg, config2_reg})
    sfcmd_host_i.xfer(28, 48'h0144556, rx);
    `CHK("cfgp", 24'h445533, {status_reg, config1_reg, config2_reg})
    op(8'h00);
    `CHK("nop", 24'h445533, {status_reg, config1_reg, config2_reg})
    sfcmd_host_i.xfer(16, 48'hc007, rx);
    `CHK("wrap", 8'h07, wrap_length)
    sfcmd_host_i.xfer(24, 48'h050000, rx);
    `CHK("rstat", 16'h4444, rx[15:0])
    sfcmd_host_i.xfer(24, 48'h150000, rx);
    `CHK("rcfg", 16'h5533, rx[15:0])
    sfcmd_host_i.xfer(16, 48'h4400, rx);
    `CHK("rfact", 8'ha5, rx[7:0])
    sfcmd_host_i.xfer(16, 48'h2b00, rx);
    `CHK("rsec", 8'h00, rx[7:0])
    op(8'h2f);
    `CHK("lock", 1'b1, security_reg[1])
    sfcmd_host_i.xfer(16, 48'h2b00, rx);
    `CHK("rsec", 8'h02, rx[7:0])
    sfcmd_host_i.xfer(40, 48'h9f << 32, rx);
    `CHK("jid", 32'h5a3c965a, rx[31:0])
    @(posedge core_clk);
    #1 busy = 1'b1;
    oe_base = n_oe;
    sfcmd_host_i.xfer(40, 48'h9f << 32, rx);
    `CHK("jidbusy", oe_base, n_oe)
    @(posedge core_clk);
    #1 busy = 1'b0;
    sfcmd_host_i.xfer(48, 48'hab << 40, rx);
    `CHK("legacy", 16'h6969, rx[15:0])
    for (int s = 0; s < 2; s++) begin
      sfcmd_host_i.xfer(48, {8'h90, 16'h0, 8'(s), 16'h0}, rx);
      `CHK("mdid", (s == 1) ? 16'h695a : 16'h5a69, rx[15:0])
    end
    // Modes set just before the reset pair must all come back clear
    op(8'h06);
    op(8'hb1);
    op(8'h66);
    op(8'h99);
    `CHK("srst", 1, n_srst)
    `CHK("modes", 4'h0, {write_enable_latch, factory_mode, deep_sleep, otp_mode})
    op(8'h66);
    op(8'h00);
    op(8'h99);
    `CHK("srstnop", 1, n_srst)
    foreach (ops[k]) op(ops[k]);
    `CHK("susp", 2, n_susp)
    `CHK("res", 2, n_res)
    finish_test();
  end
endmodule : sfcmd_top_tb
